// ===== sapm_pkg.sv
package sapm_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SAMPLE_W = 12;
	localparam int AVG_W = 3;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_STATUS_BYTE = 8'h00;
	localparam logic [7:0] OFS_STATUS_WORD = 8'h04;
	localparam logic [7:0] OFS_STATUS_INPUT = 8'h08;
	localparam logic [7:0] OFS_STATUS_OUTPUT_VOLTAGE_PIN = 8'h0c;
	localparam logic [7:0] OFS_STATUS_IOUT = 8'h10;
	localparam logic [7:0] OFS_STATUS_MFR = 8'h14;
	localparam logic [7:0] OFS_CLEAR = 8'h18;
	localparam logic [7:0] OFS_OPERATION = 8'h1c;
	localparam logic [7:0] OFS_PIN_ONE = 8'h20;
	localparam logic [7:0] OFS_PIN_TWO = 8'h24;
	localparam logic [7:0] OFS_MON_SETUP = 8'h28;
	localparam logic [7:0] OFS_MON_START = 8'h2c;
	localparam logic [7:0] OFS_PEAK_CUR = 8'h30;
	localparam logic [7:0] OFS_PEAK_INPUT_VOLTAGE_CMD = 8'h34;
	localparam logic [7:0] OFS_PEAK_OUTPUT_VOLTAGE_CMD = 8'h38;
	localparam logic [7:0] OFS_READ_CUR = 8'h3c;
	localparam logic [7:0] OFS_READ_VOLT = 8'h40;
	localparam logic [7:0] OFS_VIN_OV = 8'h44;
	localparam logic [7:0] OFS_VIN_UV = 8'h48;
	localparam logic [7:0] OFS_OUTPUT_VOLTAGE_PIN_OV = 8'h4c;
	localparam logic [7:0] OFS_OUTPUT_VOLTAGE_PIN_UV = 8'h50;
	localparam logic [7:0] OFS_IOUT_OC = 8'h54;

	// ****************************************************************
	// Latched status vector bit positions
	// ****************************************************************
	localparam int LT_VIN_OV_F = 0;
	localparam int LT_VIN_UV_F = 1;
	localparam int LT_IOUT_OC_F = 2;
	localparam int LT_VIN_OV_W = 3;
	localparam int LT_VIN_UV_W = 4;
	localparam int LT_OUTPUT_VOLTAGE_PIN_OV_W = 5;
	localparam int LT_OUTPUT_VOLTAGE_PIN_UV_W = 6;
	localparam int LT_IOUT_OC_W = 7;
	localparam int LT_N = 8;

	// ****************************************************************
	// Status register field positions
	// ****************************************************************
	localparam int SB_OFF = 6;
	localparam int SB_IOUT_OC = 4;
	localparam int SB_VIN_UV = 3;
	localparam int SB_OTHER = 0;
	localparam int SW_OUTPUT_VOLTAGE_PIN = 15;
	localparam int SW_IOUT = 14;
	localparam int SW_INPUT = 13;
	localparam int SW_MFR = 12;
	localparam int IN_OV_F = 7;
	localparam int IN_OV_W = 6;
	localparam int IN_UV_W = 5;
	localparam int IN_UV_F = 4;
	localparam int VO_OV_W = 6;
	localparam int VO_UV_W = 5;
	localparam int IO_OC_F = 7;
	localparam int IO_OC_W = 5;

	// ****************************************************************
	// Pin setup and monitor setup layouts
	// ****************************************************************
	localparam int PIN_MASK_LSB = 0;
	localparam int PIN_MODE_LSB = 8;
	localparam int PIN_LEVEL = 10;
	localparam logic [1:0] PIN_MODE_ALERT = 2'h0;
	localparam logic [1:0] PIN_MODE_SOFT = 2'h1;
	localparam logic [1:0] PIN_MODE_CONVERT = 2'h2;
	localparam int MS_CONT = 0;
	localparam int MS_OUTPUT_VOLTAGE_PIN = 1;
	localparam int MS_RANGE = 2;
	localparam int MS_IAVG_LSB = 3;
	localparam int MS_VAVG_LSB = 6;
	localparam int MS_W = 9;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic RST_OP_ON = 1'b1;
	localparam logic [10:0] RST_PIN_SETUP = 11'h000;
	localparam logic [MS_W-1:0] RST_MON_SETUP = 9'h000;
	localparam logic [SAMPLE_W-1:0] LIMIT_MAX = 12'hfff;
	localparam logic [SAMPLE_W-1:0] LIMIT_MIN = 12'h000;

	typedef enum logic {MON_IDLE, MON_BUSY} sapm_mon_e;

endpackage

// ===== sapm_peak_mem.sv
`timescale 1ns/10ps
// ****************************************************************
// Peak store: current, input voltage, output voltage
// ****************************************************************
module sapm_peak_mem
	import sapm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [2:0] updEn,
	input wire logic [3*SAMPLE_W-1:0] updVal,
	input wire logic clrEn,
	input wire logic [1:0] clrIdx,
	input wire logic [1:0] rdIdx,
	output logic [SAMPLE_W-1:0] rdData
);
	// One word per peak, index order current, input, output
	logic [SAMPLE_W-1:0] peak [3];

	// Host clear beats a sample update in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				peak[i] <= '0;
			end
		end else if (ce) begin
			for (int i = 0; i < 3; i++) begin
				if (clrEn && clrIdx == 2'(i)) begin
					peak[i] <= '0;
				end else if (updEn[i] && updVal[i*SAMPLE_W +: SAMPLE_W] > peak[i]) begin
					peak[i] <= updVal[i*SAMPLE_W +: SAMPLE_W];
				end
			end
		end
	end

	// Registered read; unused index reads zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData <= '0;
		end else if (ce) begin
			rdData <= (rdIdx == 2'h3) ? '0 : peak[rdIdx];
		end
	end
endmodule

// ===== sapm_monitor_ctrl.sv
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module sapm_monitor_ctrl
	import sapm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic pready,
	output logic [DATA_W-1:0] prdata,
	output logic pslverr,
	input wire logic overvoltageInput,
	input wire logic undervoltageInput,
	input wire logic ocTimeoutInput,
	output logic gateOff,
	input wire logic pinOneIn,
	output logic pinOneOut,
	output logic pinOneOe,
	output logic pinTwoOut,
	output logic pinTwoOe,
	output logic adcStart,
	input wire logic adcDone,
	input wire logic [SAMPLE_W-1:0] adcCurrent,
	input wire logic [SAMPLE_W-1:0] adcVoltage,
	output logic monContinuous,
	output logic monVoutSel,
	output logic monRange,
	output logic [AVG_W-1:0] monCurrentAvg,
	output logic [AVG_W-1:0] monVoltageAvg
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Strict comparisons: equality never warns
	function automatic logic above(input logic [SAMPLE_W-1:0] v, input logic [SAMPLE_W-1:0] lim);
		above = v > lim;
	endfunction

	function automatic logic below(input logic [SAMPLE_W-1:0] v, input logic [SAMPLE_W-1:0] lim);
		below = v < lim;
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [3:0] syncA; // First stage, read only by syncB
	logic [3:0] syncB; // Clean copies: ov, uv, oc, pin one
	logic convPrev; // Previous pin one level
	logic convEdge; // Rising edge in convert mode
	logic setup; // APB setup phase
	logic access; // APB access phase
	logic wrEn; // Write takes effect
	logic opOn; // Operation on-bit
	logic opOnPrev; // For low-to-high detection
	logic clearPulse; // Clear latched status
	logic [LT_N-1:0] statusLatch; // Sticky fault and warning bits
	logic [LT_N-1:0] condNow; // Present conditions
	logic [4:0] warnCond; // Warning conditions from last samples
	logic [10:0] pinOneSetup; // Mask, mode, level
	logic [10:0] pinTwoSetup;
	logic [MS_W-1:0] monSetup; // Monitor configuration
	logic [SAMPLE_W-1:0] limVinOv, limVinUv, limVoutOv, limVoutUv, limIoutOc;
	logic [SAMPLE_W-1:0] lastCurrent; // Last averaged current
	logic [SAMPLE_W-1:0] lastVoltage; // Last averaged voltage
	sapm_mon_e monState;
	logic runBit; // Continuous run requested
	logic swStart; // Software start
	logic sampleDone; // Completed measurement
	logic [7:0] summaryByte;
	logic [15:0] summaryWord;
	logic [7:0] statInput, statVout, statIout, statMfr;
	logic [DATA_W-1:0] next_read;
	logic next_hit;
	logic next_peak;
	logic [DATA_W-1:0] rdReg;
	logic hitReg;
	logic peakReg;
	logic [SAMPLE_W-1:0] peakRd;
	logic [1:0] peakWrIdx;
	logic peakClr;
	logic [1:0] peakRdIdx;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Two flops on every asynchronous input
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncA <= '0;
			syncB <= '0;
		end else if (ce) begin
			syncA <= {pinOneIn, ocTimeoutInput, undervoltageInput, overvoltageInput};
			syncB <= syncA;
		end
	end

	// Convert trigger edge, reads only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			convPrev <= 1'b0;
		end else if (ce) begin
			convPrev <= syncB[3];
		end
	end
	assign convEdge = syncB[3] && !convPrev &&
		pinOneSetup[PIN_MODE_LSB +: 2] == PIN_MODE_CONVERT;

	// ****************************************************************
	// APB decode
	// ****************************************************************
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wrEn = access && pwrite;
	// Zero wait states: read data is captured during setup
	assign pready = access;
	assign pslverr = access && !hitReg;
	assign prdata = peakReg ? {{(DATA_W-SAMPLE_W){1'b0}}, peakRd} : rdReg;

	// ****************************************************************
	// Status composition
	// ****************************************************************
	// Faults from pins, warnings from sample compares
	assign condNow = {warnCond, syncB[2], syncB[1], syncB[0]};

	always_comb begin
		summaryByte = 8'h00;
		summaryByte[SB_OFF] = gateOff; // Live, never latched
		summaryByte[SB_IOUT_OC] = statusLatch[LT_IOUT_OC_F];
		summaryByte[SB_VIN_UV] = statusLatch[LT_VIN_UV_F];
		summaryByte[SB_OTHER] = statusLatch[LT_VIN_OV_F] | (|statusLatch[LT_N-1:LT_VIN_OV_W]);
		statInput = 8'h00;
		statInput[IN_OV_F] = statusLatch[LT_VIN_OV_F];
		statInput[IN_OV_W] = statusLatch[LT_VIN_OV_W];
		statInput[IN_UV_W] = statusLatch[LT_VIN_UV_W];
		statInput[IN_UV_F] = statusLatch[LT_VIN_UV_F];
		statVout = 8'h00;
		statVout[VO_OV_W] = statusLatch[LT_OUTPUT_VOLTAGE_PIN_OV_W];
		statVout[VO_UV_W] = statusLatch[LT_OUTPUT_VOLTAGE_PIN_UV_W];
		statIout = 8'h00;
		statIout[IO_OC_F] = statusLatch[LT_IOUT_OC_F];
		statIout[IO_OC_W] = statusLatch[LT_IOUT_OC_W];
		// Live pin levels and monitor activity
		statMfr = {4'h0, monState == MON_BUSY, syncB[2], syncB[1], syncB[0]};
		summaryWord = {8'h00, summaryByte};
		summaryWord[SW_OUTPUT_VOLTAGE_PIN] = |statVout;
		summaryWord[SW_IOUT] = |statIout;
		summaryWord[SW_INPUT] = |statInput;
		summaryWord[SW_MFR] = |statMfr;
	end

	// ****************************************************************
	// Read mux
	// ****************************************************************
	always_comb begin
		next_read = '0;
		next_hit = 1'b1;
		next_peak = 1'b0;
		peakRdIdx = 2'h3;
		unique case (paddr)
			OFS_STATUS_BYTE: next_read[7:0] = summaryByte;
			OFS_STATUS_WORD: next_read[15:0] = summaryWord;
			OFS_STATUS_INPUT: next_read[7:0] = statInput;
			OFS_STATUS_OUTPUT_VOLTAGE_PIN: next_read[7:0] = statVout;
			OFS_STATUS_IOUT: next_read[7:0] = statIout;
			OFS_STATUS_MFR: next_read[7:0] = statMfr;
			OFS_CLEAR: next_read = '0;
			OFS_OPERATION: next_read[0] = opOn;
			OFS_PIN_ONE: next_read[10:0] = pinOneSetup;
			OFS_PIN_TWO: next_read[10:0] = pinTwoSetup;
			OFS_MON_SETUP: next_read[MS_W-1:0] = monSetup;
			OFS_MON_START: next_read[0] = monState == MON_BUSY;
			OFS_PEAK_CUR: begin
				next_peak = 1'b1;
				peakRdIdx = 2'h0;
			end
			OFS_PEAK_INPUT_VOLTAGE_CMD: begin
				next_peak = 1'b1;
				peakRdIdx = 2'h1;
			end
			OFS_PEAK_OUTPUT_VOLTAGE_CMD: begin
				next_peak = 1'b1;
				peakRdIdx = 2'h2;
			end
			OFS_READ_CUR: next_read[SAMPLE_W-1:0] = lastCurrent;
			OFS_READ_VOLT: next_read[SAMPLE_W-1:0] = lastVoltage;
			OFS_VIN_OV: next_read[SAMPLE_W-1:0] = limVinOv;
			OFS_VIN_UV: next_read[SAMPLE_W-1:0] = limVinUv;
			OFS_OUTPUT_VOLTAGE_PIN_OV: next_read[SAMPLE_W-1:0] = limVoutOv;
			OFS_OUTPUT_VOLTAGE_PIN_UV: next_read[SAMPLE_W-1:0] = limVoutUv;
			OFS_IOUT_OC: next_read[SAMPLE_W-1:0] = limIoutOc;
			default: next_hit = 1'b0; // Unmapped answers with an error
		endcase
	end

	// Capture read data and decode flags in setup phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdReg <= '0;
			hitReg <= 1'b0;
			peakReg <= 1'b0;
		end else if (ce && setup) begin
			rdReg <= next_read;
			hitReg <= next_hit;
			peakReg <= next_peak;
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	// Setup words; pin two has no convert mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opOn <= RST_OP_ON;
			pinOneSetup <= RST_PIN_SETUP;
			pinTwoSetup <= RST_PIN_SETUP;
			monSetup <= RST_MON_SETUP;
		end else if (ce && wrEn) begin
			if (paddr == OFS_OPERATION) begin
				opOn <= pwdata[0];
			end
			if (paddr == OFS_PIN_ONE) begin
				pinOneSetup <= pwdata[10:0];
			end
			if (paddr == OFS_PIN_TWO) begin
				pinTwoSetup <= pwdata[10:0];
			end
			// Host must stop the monitor first; not enforced here
			if (paddr == OFS_MON_SETUP) begin
				monSetup <= pwdata[MS_W-1:0];
			end
		end
	end

	// Over limits start at full scale, under limits at zero, so nothing warns
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			limVinOv <= LIMIT_MAX;
			limVinUv <= LIMIT_MIN;
			limVoutOv <= LIMIT_MAX;
			limVoutUv <= LIMIT_MIN;
			limIoutOc <= LIMIT_MAX;
		end else if (ce && wrEn) begin
			if (paddr == OFS_VIN_OV) limVinOv <= pwdata[SAMPLE_W-1:0];
			if (paddr == OFS_VIN_UV) limVinUv <= pwdata[SAMPLE_W-1:0];
			if (paddr == OFS_OUTPUT_VOLTAGE_PIN_OV) limVoutOv <= pwdata[SAMPLE_W-1:0];
			if (paddr == OFS_OUTPUT_VOLTAGE_PIN_UV) limVoutUv <= pwdata[SAMPLE_W-1:0];
			if (paddr == OFS_IOUT_OC) limIoutOc <= pwdata[SAMPLE_W-1:0];
		end
	end

	assign monContinuous = monSetup[MS_CONT];
	assign monVoutSel = monSetup[MS_OUTPUT_VOLTAGE_PIN];
	assign monRange = monSetup[MS_RANGE];
	assign monCurrentAvg = monSetup[MS_IAVG_LSB +: AVG_W];
	assign monVoltageAvg = monSetup[MS_VAVG_LSB +: AVG_W];

	// ****************************************************************
	// Latched status and clearing
	// ****************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opOnPrev <= RST_OP_ON;
		end else if (ce) begin
			opOnPrev <= opOn;
		end
	end
	// Clear command, or on-bit taken low then high again
	assign clearPulse = (wrEn && paddr == OFS_CLEAR) || (opOn && !opOnPrev);

	// Set wins over clear: active conditions return at once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			statusLatch <= '0;
		end else if (ce) begin
			statusLatch <= condNow | (statusLatch & ~{LT_N{clearPulse}});
		end
	end

	// Gate drive off on any fault or when operation says off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gateOff <= 1'b0;
		end else if (ce) begin
			gateOff <= !opOn || (|condNow[LT_IOUT_OC_F:LT_VIN_OV_F]);
		end
	end

	// ****************************************************************
	// Multipurpose pins
	// ****************************************************************
	// Alert pulls low while a masked latched bit stands
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinOneOut <= 1'b0;
			pinOneOe <= 1'b0;
			pinTwoOut <= 1'b0;
			pinTwoOe <= 1'b0;
		end else if (ce) begin
			unique case (pinOneSetup[PIN_MODE_LSB +: 2])
				PIN_MODE_SOFT: begin
					pinOneOut <= pinOneSetup[PIN_LEVEL];
					pinOneOe <= 1'b1;
				end
				PIN_MODE_CONVERT: begin
					pinOneOut <= 1'b0;
					pinOneOe <= 1'b0;
				end
				default: begin
					pinOneOut <= 1'b0;
					pinOneOe <= |(statusLatch & pinOneSetup[PIN_MASK_LSB +: LT_N]);
				end
			endcase
			if (pinTwoSetup[PIN_MODE_LSB +: 2] == PIN_MODE_SOFT) begin
				pinTwoOut <= pinTwoSetup[PIN_LEVEL];
				pinTwoOe <= 1'b1;
			end else begin
				pinTwoOut <= 1'b0;
				pinTwoOe <= |(statusLatch & pinTwoSetup[PIN_MASK_LSB +: LT_N]);
			end
		end
	end

	// ****************************************************************
	// Monitor sequencing
	// ****************************************************************
	assign swStart = wrEn && paddr == OFS_MON_START && pwdata[0];
	assign sampleDone = monState == MON_BUSY && adcDone;

	// Continuous runs repeat until stopped; pin triggers once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			monState <= MON_IDLE;
			adcStart <= 1'b0;
			runBit <= 1'b0;
		end else if (ce) begin
			adcStart <= 1'b0;
			if (wrEn && paddr == OFS_MON_START && !pwdata[0]) begin
				runBit <= 1'b0; // Stop after present cycle
			end
			unique case (monState)
				MON_IDLE: begin
					if (swStart || convEdge) begin
						adcStart <= 1'b1;
						runBit <= swStart && monContinuous;
						monState <= MON_BUSY;
					end
				end
				MON_BUSY: begin
					if (adcDone) begin
						if (runBit && monContinuous) begin
							adcStart <= 1'b1;
						end else begin
							runBit <= 1'b0;
							monState <= MON_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Samples and warning compares on each finished measurement
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lastCurrent <= '0;
			lastVoltage <= '0;
			warnCond <= '0;
		end else if (ce && sampleDone) begin
			lastCurrent <= adcCurrent;
			lastVoltage <= adcVoltage;
			warnCond[LT_IOUT_OC_W-LT_VIN_OV_W] <= above(adcCurrent, limIoutOc);
			if (monVoutSel) begin
				warnCond[LT_OUTPUT_VOLTAGE_PIN_OV_W-LT_VIN_OV_W] <= above(adcVoltage, limVoutOv);
				warnCond[LT_OUTPUT_VOLTAGE_PIN_UV_W-LT_VIN_OV_W] <= below(adcVoltage, limVoutUv);
			end else begin
				warnCond[0] <= above(adcVoltage, limVinOv);
				warnCond[LT_VIN_UV_W-LT_VIN_OV_W] <= below(adcVoltage, limVinUv);
			end
		end
	end

	// ****************************************************************
	// Peak store
	// ****************************************************************
	assign peakClr = wrEn && pwdata == '0 &&
		(paddr == OFS_PEAK_CUR || paddr == OFS_PEAK_INPUT_VOLTAGE_CMD || paddr == OFS_PEAK_OUTPUT_VOLTAGE_CMD);
	assign peakWrIdx = 2'(paddr[3:2] - 2'h0);

	sapm_peak_mem u_peak (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.updEn({sampleDone && monVoutSel, sampleDone && !monVoutSel, sampleDone}),
		.updVal({adcVoltage, adcVoltage, adcCurrent}),
		.clrEn(peakClr),
		.clrIdx(peakWrIdx),
		.rdIdx(peakRdIdx),
		.rdData(peakRd)
	);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !ce);

	sequence s_convert_trigger_mode_rise;
		convEdge && monState == MON_IDLE;
	endsequence
	sequence s_start_busy;
		adcStart && monState == MON_BUSY;
	endsequence
	property p_convert_trigger_mode_start;
		s_convert_trigger_mode_rise |=> s_start_busy;
	endproperty
	a_convert_trigger_mode_start: assert property (p_convert_trigger_mode_start) else $error("convert edge did not start");
	property p_latch_hold;
		!clearPulse |=> ((statusLatch & $past(statusLatch)) == $past(statusLatch));
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched bit lost");
	property p_clear_live;
		clearPulse |=> statusLatch == $past(condNow);
	endproperty
	a_clear_live: assert property (p_clear_live) else $error("clear result wrong");
	property p_word_low;
		hitReg && access && paddr == OFS_STATUS_WORD |-> prdata[7:0] == $past(summaryByte);
	endproperty
	a_word_low: assert property (p_word_low) else $error("word low byte mismatch");
	property p_alert_hold;
		pinTwoSetup[PIN_MODE_LSB +: 2] != PIN_MODE_SOFT &&
		|(statusLatch & pinTwoSetup[PIN_MASK_LSB +: LT_N]) |=> pinTwoOe && !pinTwoOut;
	endproperty
	a_alert_hold: assert property (p_alert_hold) else $error("alert two not asserted");
	property p_soft_out;
		pinOneSetup[PIN_MODE_LSB +: 2] == PIN_MODE_SOFT |=>
			pinOneOe && pinOneOut == $past(pinOneSetup[PIN_LEVEL]);
	endproperty
	a_soft_out: assert property (p_soft_out) else $error("soft output wrong");
	property p_convert_trigger_mode_input;
		pinOneSetup[PIN_MODE_LSB +: 2] == PIN_MODE_CONVERT |=> !pinOneOe;
	endproperty
	a_convert_trigger_mode_input: assert property (p_convert_trigger_mode_input) else $error("convert pin driven");
	property p_fault_gate;
		(|condNow[LT_IOUT_OC_F:LT_VIN_OV_F]) |=> gateOff;
	endproperty
	a_fault_gate: assert property (p_fault_gate) else $error("fault left gate on");
	property p_strict;
		sampleDone && !monVoutSel && adcVoltage == limVinOv |=> !warnCond[0];
	endproperty
	a_strict: assert property (p_strict) else $error("equality raised warning");
endmodule

// ===== sapm_adc_model.sv
`timescale 1ns/10ps
// Converter stand-in: answers each start after LAT cycles
module sapm_adc_model
	import sapm_pkg::*;
#(
	parameter int LAT = 4
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic adcStart,
	input wire logic [SAMPLE_W-1:0] curSet,
	input wire logic [SAMPLE_W-1:0] voltSet,
	output logic adcDone,
	output logic [SAMPLE_W-1:0] adcCurrent,
	output logic [SAMPLE_W-1:0] adcVoltage
);
	int cnt;
	// Done pulses once for each start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			adcDone <= 1'b0;
		end else begin
			adcDone <= (cnt == 1);
			cnt <= adcStart ? LAT : (cnt > 0 ? cnt - 1 : 0);
		end
	end
	// Samples inverted outside done, so stale capture shows up
	assign adcCurrent = adcDone ? curSet : ~curSet;
	assign adcVoltage = adcDone ? voltSet : ~voltSet;
endmodule

// ===== status_alert_power_monitor_control_tb_top.sv
`timescale 1ns/10ps
module status_alert_power_monitor_control_tb_top
	import sapm_pkg::*;
;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, gateOff, pinOneOut, pinOneOe, pinTwoOut, pinTwoOe, lastErr;
	logic adcStart, adcDone, monContinuous, monVoutSel, monRange;
	logic overvoltageInput = 1'b0, undervoltageInput = 1'b0, ocTimeoutInput = 1'b0;
	logic pinOneIn = 1'b0;
	logic [SAMPLE_W-1:0] adcCurrent, adcVoltage, curSet = 12'h010, voltSet = 12'h064;
	logic [AVG_W-1:0] monCurrentAvg, monVoltageAvg;
	int errors = 0, tests_run = 0;
	always #12.5 clk = ~clk;
	sapm_monitor_ctrl sapm_monitor_ctrl_i (
		.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.overvoltageInput(overvoltageInput), .undervoltageInput(undervoltageInput),
		.ocTimeoutInput(ocTimeoutInput), .gateOff(gateOff), .pinOneIn(pinOneIn),
		.pinOneOut(pinOneOut), .pinOneOe(pinOneOe), .pinTwoOut(pinTwoOut), .pinTwoOe(pinTwoOe),
		.adcStart(adcStart), .adcDone(adcDone), .adcCurrent(adcCurrent),
		.adcVoltage(adcVoltage), .monContinuous(monContinuous), .monVoutSel(monVoutSel),
		.monRange(monRange), .monCurrentAvg(monCurrentAvg), .monVoltageAvg(monVoltageAvg)
	);
	sapm_adc_model #(.LAT(4)) sapm_adc_model_i (
		.clk(clk), .rst(rst), .adcStart(adcStart), .curSet(curSet), .voltSet(voltSet),
		.adcDone(adcDone), .adcCurrent(adcCurrent), .adcVoltage(adcVoltage)
	);
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; an edge passes first so strobes never toggle twice
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) errors++;
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Two spare cycles let registered clears land before the read
	task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
		repeat (2) @(posedge clk);
		apb(1'b0, a, 32'h0);
		chk(what, q, exp);
	endtask
	// Bounded wait for a converter start or done pulse
	task automatic waitEv(input logic onStart);
		int n;
		n = 0;
		while ((onStart ? adcStart : adcDone) !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n == 100) errors++;
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdChk("operation", OFS_OPERATION, 32'h1);
		rdChk("vin ov limit", OFS_VIN_OV, 32'hfff);
		rdChk("vin uv limit", OFS_VIN_UV, 32'h0);
		rdChk("unmapped", 8'hfc, 32'h0);
		chk("slave error", 32'(lastErr), 32'h1);
		$display("test reset values done");
		// Undervoltage fault with pin two alerting on it
		undervoltageInput <= 1'b1;
		apb(1'b1, OFS_PIN_TWO, 32'h2);
		repeat (6) @(posedge clk);
		rdChk("status byte", OFS_STATUS_BYTE, 32'h48);
		// Live undervoltage pin level also raises the mfr pointer
		rdChk("status word", OFS_STATUS_WORD, 32'h3048);
		chk("gate off", 32'(gateOff), 32'h1);
		chk("pin two alert", 32'({pinTwoOe, pinTwoOut}), 32'h2);
		apb(1'b1, OFS_CLEAR, 32'h0);
		rdChk("clear while active", OFS_STATUS_INPUT, 32'h10);
		undervoltageInput <= 1'b0;
		repeat (6) @(posedge clk);
		rdChk("latched", OFS_STATUS_BYTE, 32'h08);
		apb(1'b1, OFS_CLEAR, 32'h0);
		rdChk("cleared", OFS_STATUS_BYTE, 32'h0);
		chk("pin two idle", 32'({pinTwoOe, pinTwoOut}), 32'h0);
		apb(1'b1, OFS_PIN_TWO, 32'h502);
		repeat (2) @(posedge clk);
		chk("pin two soft", 32'({pinTwoOe, pinTwoOut}), 32'h3);
		overvoltageInput <= 1'b1;
		repeat (6) @(posedge clk);
		overvoltageInput <= 1'b0;
		rdChk("ov fault", OFS_STATUS_INPUT, 32'h80);
		apb(1'b1, OFS_OPERATION, 32'h0);
		apb(1'b1, OFS_OPERATION, 32'h1);
		rdChk("operation clear", OFS_STATUS_INPUT, 32'h0);
		ocTimeoutInput <= 1'b1;
		repeat (6) @(posedge clk);
		ocTimeoutInput <= 1'b0;
		rdChk("oc fault", OFS_STATUS_IOUT, 32'h80);
		$display("test faults done");
		// Monitor: equal sample is quiet, one above warns
		apb(1'b1, OFS_VIN_OV, 32'h064);
		apb(1'b1, OFS_MON_SETUP, 32'h0);
		apb(1'b1, OFS_MON_START, 32'h1);
		waitEv(1'b0);
		rdChk("equal no warn", OFS_STATUS_INPUT, 32'h0);
		rdChk("peak current", OFS_PEAK_CUR, 32'h010);
		voltSet <= 12'h065;
		apb(1'b1, OFS_MON_START, 32'h1);
		waitEv(1'b0);
		rdChk("above warns", OFS_STATUS_INPUT, 32'h40);
		rdChk("peak_input_voltage_cmd", OFS_PEAK_INPUT_VOLTAGE_CMD, 32'h065);
		apb(1'b1, OFS_PEAK_INPUT_VOLTAGE_CMD, 32'h0);
		rdChk("peak_input_voltage_cmd cleared", OFS_PEAK_INPUT_VOLTAGE_CMD, 32'h0);
		rdChk("peak current kept", OFS_PEAK_CUR, 32'h010);
		chk("warning leaves gate", 32'(gateOff), 32'h0);
		$display("test monitor done");
		apb(1'b1, OFS_PIN_ONE, 32'h500);
		repeat (2) @(posedge clk);
		chk("pin one soft", 32'({pinOneOe, pinOneOut}), 32'h3);
		// Convert mode: pin one becomes a trigger input
		apb(1'b1, OFS_PIN_ONE, 32'h200);
		pinOneIn <= 1'b1;
		waitEv(1'b1);
		chk("pin one input", 32'(pinOneOe), 32'h0);
		waitEv(1'b0);
		rdChk("peak after convert", OFS_PEAK_INPUT_VOLTAGE_CMD, 32'h065);
		$display("test convert done");
		// Setup fields reach the converter; continuous runs until stopped
		apb(1'b1, OFS_MON_SETUP, 32'h1f6);
		repeat (2) @(posedge clk);
		chk("monitor setup", 32'({monVoltageAvg, monCurrentAvg, monRange, monVoutSel,
			monContinuous}), 32'h1f6);
		apb(1'b1, OFS_MON_SETUP, 32'h1);
		apb(1'b1, OFS_MON_START, 32'h1);
		waitEv(1'b0);
		waitEv(1'b1);
		rdChk("continuous busy", OFS_MON_START, 32'h1);
		apb(1'b1, OFS_MON_START, 32'h0);
		waitEv(1'b0);
		rdChk("stopped idle", OFS_MON_START, 32'h0);
		$display("test continuous done");
		tally_and_finish();
	end
	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		tally_and_finish();
	end
endmodule
